// *** bench/fea_array_model.sv ***
// Behavioural flash array on the far side of the controller.
// Assumes erase fields are valid while the erase active flag is high.
`timescale 1ns/1ns
`default_nettype none
module fea_array_model import fea_pkg::*; (
  input  wire logic               i_clk,
  input  wire fea_pkg::fea_arr_s   i_arr,
  input  wire fea_pkg::fea_erase_s i_erase,
  output logic [7:0]              o_rdata
);
  logic [7:0] mm [0:262143];
  logic [7:0] im [0:2047];
  logic [7:0] v;
  logic       act = 1'b0;
  initial begin
    for (int a = 0; a < 262144; a++) mm[a] = 8'(a) ^ 8'(a >> 8);
    for (int a = 0; a < 2048; a++) im[a] = 8'(a) ^ 8'h5a;
  end
  // The info page is a separate store, so memory cycles cannot reach it.
  assign v = i_arr.info ? im[i_arr.addr[10:0]] : mm[i_arr.addr];
  // A released bus shows the inverse, never a stale byte that could pass.
  assign o_rdata = i_arr.rd ? v : ~v;
  always @(posedge i_clk) begin
    act <= i_erase.active;
    if (i_erase.active && !act) begin
      for (int a = 0; a < 262144; a++) begin
        if (i_erase.mass || (!i_erase.info && 7'(a >> 11) == i_erase.page)) mm[a] = ERASED_BYTE;
      end
      if (i_erase.info) for (int a = 0; a < 2048; a++) im[a] = ERASED_BYTE;
    end
    if (i_arr.wr && i_arr.info) im[i_arr.addr[10:0]] &= i_arr.wdata;
    if (i_arr.wr && !i_arr.info) mm[i_arr.addr] &= i_arr.wdata;
  end
endmodule
`default_nettype wire

// *** bench/fea_ctrl_chk.sv ***
// Port assertions for the flash erase and access control block.
// Assumes one system clock and an active-low asynchronous reset.
`timescale 1ns/1ns
`default_nettype none
module fea_ctrl_chk import fea_pkg::*; #(
  parameter int MASS_CYC = 40,
  parameter int PAGE_CYC = 20
) (
  input wire logic                  i_clk,
  input wire logic                  i_nrst,
  input wire fea_pkg::fea_cpu_req_s i_req,
  input wire logic                  i_sram_hit,
  input wire logic                  i_irq_status_rd,
  input wire logic                  o_ack,
  input wire logic                  o_ext_cs_inhibit,
  input wire fea_pkg::fea_erase_s   o_erase,
  input wire logic                  o_erase_done_flag,
  input wire logic [17:0]           o_io_addr,
  input wire logic [7:0]            o_clock_divider,
  input wire logic [7:0]            o_write_erase_guard
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_nrst);
  localparam int PG = PAGE_CYC - 1;
  localparam int MS = MASS_CYC - 1;
  logic key1, unl, next_key1, next_unl, kw, gw, wr;
  assign wr = o_ack && i_req.io_wr;
  assign kw = i_req.io_addr == KEY_OFS;
  assign gw = i_req.io_addr == DIV_OFS || i_req.io_addr == GUARD_OFS;
  ////////////////////////////////////////////////////////////////////////////
  // Key state shadow; only acknowledged I/O writes move it.
  always_comb begin
    next_key1 = key1;
    next_unl  = unl;
    if (wr) begin
      next_key1 = kw && i_req.wdata == KEY_FIRST;
      next_unl  = (unl || (key1 && kw && i_req.wdata == KEY_SECOND)) && !gw;
    end
  end
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      key1 <= 1'b0;
      unl  <= 1'b0;
    end else begin
      key1 <= next_key1;
      unl  <= next_unl;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  property p_page_len;
    $rose(o_erase.active) && !o_erase.mass |-> ##PG o_erase.active ##[1:4] !o_erase.active;
  endproperty
  a_page_len: assert property (p_page_len) else $error("page erase length wrong");
  property p_mass_len;
    $rose(o_erase.active) && o_erase.mass |-> ##MS o_erase.active ##[1:4] !o_erase.active;
  endproperty
  a_mass_len: assert property (p_mass_len) else $error("mass erase length wrong");
  property p_flag_clr;
    i_irq_status_rd && !o_erase.active |=> !o_erase_done_flag;
  endproperty
  a_flag_clr: assert property (p_flag_clr) else $error("done flag not cleared");
  property p_hold;
    o_erase.active && i_req.io_rd && i_req.io_addr == DATA_OFS |-> !o_ack;
  endproperty
  a_hold: assert property (p_hold) else $error("flash access answered during erase");
  property p_inc;
    o_ack && (i_req.io_rd || i_req.io_wr) && i_req.io_addr == DATA_OFS |-> o_io_addr == 18'($past(o_io_addr) + 1);
  endproperty
  a_inc: assert property (p_inc) else $error("data port address not advanced");
  property p_guard_lock;
    wr && i_req.io_addr == GUARD_OFS && !unl |=> o_write_erase_guard == GUARD_ALL;
  endproperty
  a_guard_lock: assert property (p_guard_lock) else $error("locked guard write not forced");
  property p_div_lock;
    wr && i_req.io_addr == DIV_OFS && !unl |=> o_clock_divider == $past(o_clock_divider, 2);
  endproperty
  a_div_lock: assert property (p_div_lock) else $error("locked divider changed");
  property p_div_open;
    wr && i_req.io_addr == DIV_OFS && unl |=> o_clock_divider == $past(i_req.wdata);
  endproperty
  a_div_open: assert property (p_div_open) else $error("unlocked divider not written");
  property p_sram;
    i_req.mem_rd && i_sram_hit |=> !o_ext_cs_inhibit;
  endproperty
  a_sram: assert property (p_sram) else $error("select inhibited on SRAM hit");
endmodule
bind fea_ctrl fea_ctrl_chk #(.MASS_CYC(MASS_CYC), .PAGE_CYC(PAGE_CYC)) u_chk (.i_clk, .i_nrst, .i_req,
  .i_sram_hit, .i_irq_status_rd, .o_ack, .o_ext_cs_inhibit, .o_erase, .o_erase_done_flag, .o_io_addr,
  .o_clock_divider, .o_write_erase_guard);
`default_nettype wire

// *** bench/tb_top.sv ***
// Self-checking bench for the flash erase and access control block.
// Assumes the array model on the far side and the bound checker.
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin fails++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, (a), (e)); end end
module tb_top;
  import fea_pkg::*;
  localparam int MC = 40;
  localparam int PC = 20;
  localparam logic [3:0] RD = 4'b1000;
  localparam logic [3:0] WR = 4'b0100;
  localparam logic [3:0] MR = 4'b0010;
  localparam logic [3:0] MW = 4'b0001;
  logic         i_clk = 1'b0;
  logic         i_nrst, sram, ld, aux, mst, pst, irq, ack, wt, cs, done, csq;
  fea_cpu_req_s i_req;
  fea_arr_s     arr;
  fea_erase_s   ers;
  logic [17:0]  av, ioa;
  logic [7:0]   rdat, rd, q, dv, gd;
  int           fails = 0;
  int           checks = 0;
  int           ws = 0;
  fea_ctrl #(.MASS_CYC(MC), .PAGE_CYC(PC)) uut (.i_clk(i_clk), .i_nrst(i_nrst), .i_req(i_req),
    .i_sram_hit(sram), .i_addr_load(ld), .i_addr_value(av), .i_aux_area_enable(aux),
    .i_mass_erase_start(mst), .i_page_erase_start(pst), .i_irq_status_rd(irq), .i_arr_rdata(rdat),
    .o_ack(ack), .o_wait(wt), .o_rdata(rd), .o_ext_cs_inhibit(cs), .o_arr(arr), .o_erase(ers),
    .o_erase_done_flag(done), .o_io_addr(ioa), .o_clock_divider(dv), .o_write_erase_guard(gd));
  fea_array_model u_arr (.i_clk(i_clk), .i_arr(arr), .i_erase(ers), .o_rdata(rdat));
  always #10 i_clk = ~i_clk;
  function automatic logic [7:0] pat(input logic [17:0] a);
    return a[7:0] ^ a[15:8];
  endfunction
  ////////////////////////////////////////////////////////////////////////////
  // Holds a request until the acknowledge is sampled; gives up after 200.
  task automatic acc(input logic [3:0] k, input logic [23:0] a, input logic [7:0] d, output int l);
    @(posedge i_clk);
    i_req <= {k, a[7:0], a, d};
    l = 0;
    ws = 0;
    do begin
      @(negedge i_clk);
      l++;
      if (wt === 1'b1) begin
        ws++;
      end
    end while (ack !== 1'b1 && l < 200);
    q = rd;
    csq = cs;
    @(posedge i_clk);
    i_req <= '0;
  endtask
  task automatic set_addr(input logic [17:0] a);
    @(posedge i_clk);
    ld <= 1'b1;
    av <= a;
    @(posedge i_clk);
    ld <= 1'b0;
  endtask
  task automatic t_regs;
    int l;
    `CHK(dv, DIV_RST)
    `CHK(gd, GUARD_RST)
    acc(RD, CTRL_OFS, 8'h00, l);
    `CHK(q, CTRL_RST)
    acc(WR, BASE_OFS, 8'h47, l);
    acc(RD, BASE_OFS, 8'h00, l);
    `CHK(q, 8'h44)
  endtask
  task automatic t_wait;
    int l, l0, l4, w0;
    logic [17:0] e;
    e = 18'h00100;
    set_addr(e);
    acc(RD, DATA_OFS, 8'h00, l4);
    for (int n = 0; n < 8; n++) begin
      acc(WR, CTRL_OFS, {3'(n), 5'h08}, l);
      e = e + 18'h1;
      acc(RD, DATA_OFS, 8'h00, l);
      if (n == 0) begin
        l0 = l;
        w0 = ws;
      end
      `CHK(l - l0, n)
      `CHK(ws - w0, n)
      `CHK(q, pat(e))
      `CHK(ioa, e + 18'h1)
    end
    `CHK(l4 - l0, 4)
    acc(WR, CTRL_OFS, CTRL_RST, l);
  endtask
  task automatic t_mem;
    int l;
    acc(MR, 24'h450456, 8'h00, l);
    `CHK(q, pat(18'h10456))
    `CHK(csq, 1'b1)
    acc(MR, 24'h000456, 8'h00, l);
    `CHK(l, 200)
    `CHK(csq, 1'b0)
    sram <= 1'b1;
    acc(MR, 24'h450456, 8'h00, l);
    `CHK(l, 200)
    `CHK(csq, 1'b0)
    sram <= 1'b0;
    acc(WR, CTRL_OFS, 8'h00, l);
    acc(MR, 24'h450456, 8'h00, l);
    `CHK(l, 200)
    `CHK(csq, 1'b0)
    set_addr(18'h00777);
    acc(RD, DATA_OFS, 8'h00, l);
    `CHK(q, pat(18'h00777))
    acc(WR, CTRL_OFS, CTRL_RST, l);
    acc(WR, BASE_OFS, BASE_RST, l);
  endtask
  task automatic t_key;
    int l;
    acc(WR, KEY_OFS, KEY_FIRST, l);
    acc(WR, KEY_OFS, KEY_SECOND, l);
    acc(WR, DIV_OFS, 8'h05, l);
    `CHK(dv, 8'h05)
    acc(WR, DIV_OFS, 8'h07, l);
    `CHK(dv, 8'h05)
    acc(WR, GUARD_OFS, 8'h00, l);
    `CHK(gd, GUARD_ALL)
    acc(WR, KEY_OFS, KEY_FIRST, l);
    acc(RD, CTRL_OFS, 8'h00, l);
    acc(MR, 24'h000010, 8'h00, l);
    acc(WR, KEY_OFS, KEY_SECOND, l);
    acc(WR, GUARD_OFS, 8'h3c, l);
    `CHK(gd, 8'h3c)
    acc(WR, KEY_OFS, KEY_FIRST, l);
    acc(WR, CTRL_OFS, CTRL_RST, l);
    acc(WR, KEY_OFS, KEY_SECOND, l);
    acc(WR, DIV_OFS, 8'h09, l);
    `CHK(dv, 8'h05)
    acc(RD, KEY_OFS, 8'h00, l);
    `CHK(q, 8'h00)
  endtask
  // Starts one erase, then reads the target while it runs.
  task automatic erase(input logic m, input logic [17:0] a);
    int l;
    set_addr(a);
    @(posedge i_clk);
    mst <= m;
    pst <= !m;
    @(posedge i_clk);
    mst <= 1'b0;
    pst <= 1'b0;
    acc(RD, CTRL_OFS, 8'h00, l);
    `CHK(l < 5, 1'b1)
    acc(RD, DATA_OFS, 8'h00, l);
    `CHK(l > (m ? MC : PC) - 6, 1'b1)
    `CHK(ws > (m ? MC : PC) - 6, 1'b1)
    `CHK(q, ERASED_BYTE)
    `CHK(done, 1'b1)
    @(posedge i_clk);
    irq <= 1'b1;
    @(posedge i_clk);
    irq <= 1'b0;
    @(negedge i_clk);
    `CHK(done, 1'b0)
  endtask
  task automatic t_erase;
    int l;
    set_addr({7'd3, 11'h010});
    acc(WR, DATA_OFS, 8'h00, l);
    set_addr({7'd3, 11'h010});
    acc(RD, DATA_OFS, 8'h00, l);
    `CHK(q, 8'h00)
    erase(1'b0, {7'd3, 11'h010});
    set_addr({7'd4, 11'h010});
    acc(RD, DATA_OFS, 8'h00, l);
    `CHK(q, pat({7'd4, 11'h010}))
    erase(1'b1, 18'h2a006);
    aux <= 1'b1;
    set_addr(18'h00005);
    acc(RD, DATA_OFS, 8'h00, l);
    `CHK(q, 8'h5f)
    acc(MR, 24'h000005, 8'h00, l);
    `CHK(q, ERASED_BYTE)
    // A memory write with the info page selected must still land in the main array.
    acc(MW, 24'h000100, 8'h3c, l);
    acc(MR, 24'h000100, 8'h00, l);
    `CHK(q, 8'h3c)
    set_addr(18'h00100);
    acc(RD, DATA_OFS, 8'h00, l);
    `CHK(q, 8'h5a)
    erase(1'b0, 18'h00005);
    aux <= 1'b0;
  endtask
  task automatic report_and_stop;
    if (fails == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    {i_nrst, sram, ld, aux, mst, pst, irq} = '0;
    i_req = '0;
    av = '0;
    repeat (3) @(posedge i_clk);
    i_nrst <= 1'b1;
    t_regs();
    t_wait();
    t_mem();
    t_key();
    t_erase();
    report_and_stop();
  end
  initial begin
    #300000;
    fails++;
    report_and_stop();
  end
endmodule
`default_nettype wire

// *** rtl/fea_ctrl.sv ***
// Flash erase sequencing, guarded registers, I/O data port and memory window.
// Assumes CPU requests are levels held until o_ack and dropped in the ack cycle.
`timescale 1ns/1ns
`default_nettype none
module fea_ctrl #(
  parameter int MASS_CYC = fea_pkg::MASS_ERASE_CYC,
  parameter int PAGE_CYC = fea_pkg::PAGE_ERASE_CYC
) (
  input  wire logic                  i_clk,
  input  wire logic                  i_nrst,
  input  wire fea_pkg::fea_cpu_req_s i_req,
  input  wire logic                  i_sram_hit,
  input  wire logic                  i_addr_load,
  input  wire logic [17:0]           i_addr_value,
  input  wire logic                  i_aux_area_enable,
  input  wire logic                  i_mass_erase_start,
  input  wire logic                  i_page_erase_start,
  input  wire logic                  i_irq_status_rd,
  input  wire logic [7:0]            i_arr_rdata,
  output logic                       o_ack,
  output logic                       o_wait,
  output logic [7:0]                 o_rdata,
  output logic                       o_ext_cs_inhibit,
  output fea_pkg::fea_arr_s          o_arr,
  output fea_pkg::fea_erase_s        o_erase,
  output logic                       o_erase_done_flag,
  output logic [17:0]                o_io_addr,
  output logic [7:0]                 o_clock_divider,
  output logic [7:0]                 o_write_erase_guard
);
  import fea_pkg::*;

  function automatic logic is_window(input logic [7:0] base, input logic [23:0] a);
    is_window = (a[23:ADDR_W] == base[7:2]);
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Register state and decode.

  logic [7:0]  base_upper;
  logic [7:0]  access_ctrl;
  logic        unlocked;
  logic        key_first;
  logic        io_wr_q;
  logic [7:0]  next_base_upper;
  logic [7:0]  next_access_ctrl;
  logic [7:0]  next_divider;
  logic [7:0]  next_guard;
  logic        next_unlocked;
  logic        next_key_first;
  logic        win_en;
  logic [2:0]  wait_cnt_cfg;
  logic        mem_hit;
  logic        io_ours;
  logic        io_new_wr;
  logic        erase_busy;
  logic        erase_done;

  assign win_en       = access_ctrl[CTRL_EN_BIT];
  assign wait_cnt_cfg = access_ctrl[CTRL_WAIT_MSB:CTRL_WAIT_LSB];
  // SRAM claims its addresses first, so flash never answers there.
  assign mem_hit   = win_en && !i_sram_hit && is_window(base_upper, i_req.mem_addr);
  assign io_ours   = (i_req.io_addr >= KEY_OFS) && (i_req.io_addr <= GUARD_OFS);
  assign io_new_wr = i_req.io_wr && !io_wr_q;

  ////////////////////////////////////////////////////////////////////////////////
  // Access state machine.

  fea_state_e        state;
  fea_state_e        next_state;
  logic [2:0]        wcnt;
  logic [2:0]        next_wcnt;
  logic              acc_io;
  logic              acc_wr;
  logic              acc_data;
  logic [7:0]        acc_reg;
  logic [ADDR_W-1:0] acc_addr;
  logic [7:0]        acc_wdata;
  logic              next_acc_io;
  logic              next_acc_wr;
  logic              next_acc_data;
  logic [7:0]        next_acc_reg;
  logic [ADDR_W-1:0] next_acc_addr;
  logic [7:0]        next_acc_wdata;
  logic              start_req;
  logic              start_flash;
  logic              finish;

  assign start_req   = (i_req.mem_rd || i_req.mem_wr) ? mem_hit : ((i_req.io_rd || i_req.io_wr) && io_ours);
  assign start_flash = (i_req.mem_rd || i_req.mem_wr) || (i_req.io_addr == DATA_OFS);
  assign finish      = (state == FEA_COUNT) && (wcnt == 3'h0);

  always_comb begin
    next_state     = state;
    next_wcnt      = wcnt;
    next_acc_io    = acc_io;
    next_acc_wr    = acc_wr;
    next_acc_data  = acc_data;
    next_acc_reg   = acc_reg;
    next_acc_addr  = acc_addr;
    next_acc_wdata = acc_wdata;
    case (state)
      FEA_IDLE: begin
        if (start_req) begin
          next_acc_io    = i_req.io_rd || i_req.io_wr;
          next_acc_wr    = i_req.io_wr || i_req.mem_wr;
          next_acc_data  = start_flash;
          next_acc_reg   = i_req.io_addr;
          // Memory cycles only ever reach the main array.
          next_acc_addr  = next_acc_io ? o_io_addr : i_req.mem_addr[ADDR_W-1:0];
          next_acc_wdata = i_req.wdata;
          next_wcnt      = start_flash ? wait_cnt_cfg : 3'h0;
          next_state     = (start_flash && erase_busy) ? FEA_HOLD : FEA_COUNT;
        end
      end
      FEA_HOLD: begin
        if (!erase_busy) begin
          next_state = FEA_COUNT;
        end
      end
      FEA_COUNT: begin
        if (wcnt == 3'h0) begin
          next_state = FEA_DONE;
        end else begin
          next_wcnt = wcnt - 3'h1;
        end
      end
      FEA_DONE: begin
        next_state = FEA_IDLE;
      end
      default: begin
        next_state = FEA_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      state     <= FEA_IDLE;
      wcnt      <= 3'h0;
      acc_io    <= 1'b0;
      acc_wr    <= 1'b0;
      acc_data  <= 1'b0;
      acc_reg   <= 8'h00;
      acc_addr  <= '0;
      acc_wdata <= 8'h00;
    end else begin
      state     <= next_state;
      wcnt      <= next_wcnt;
      acc_io    <= next_acc_io;
      acc_wr    <= next_acc_wr;
      acc_data  <= next_acc_data;
      acc_reg   <= next_acc_reg;
      acc_addr  <= next_acc_addr;
      acc_wdata <= next_acc_wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Configuration, key sequence and guarded registers.

  logic reg_wr;
  assign reg_wr = finish && acc_io && acc_wr;

  always_comb begin
    next_base_upper  = base_upper;
    next_access_ctrl = access_ctrl;
    next_divider     = o_clock_divider;
    next_guard       = o_write_erase_guard;
    next_unlocked    = unlocked;
    next_key_first   = key_first;
    // Any new I/O write, to any address, moves the key tracker.
    if (io_new_wr) begin
      next_key_first = (i_req.io_addr == KEY_OFS) && (i_req.wdata == KEY_FIRST);
      if (key_first && (i_req.io_addr == KEY_OFS) && (i_req.wdata == KEY_SECOND)) begin
        next_unlocked = 1'b1;
      end
    end
    if (reg_wr) begin
      case (acc_reg)
        BASE_OFS: next_base_upper = acc_wdata & BASE_WMASK;
        CTRL_OFS: next_access_ctrl = acc_wdata & CTRL_WMASK;
        DIV_OFS: begin
          if (unlocked) begin
            next_divider = acc_wdata;
          end
          next_unlocked = 1'b0;
        end
        GUARD_OFS: begin
          next_guard    = unlocked ? acc_wdata : GUARD_ALL;
          next_unlocked = 1'b0;
        end
        default: begin
          next_base_upper = base_upper;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      base_upper          <= BASE_RST;
      access_ctrl         <= CTRL_RST;
      o_clock_divider     <= DIV_RST;
      o_write_erase_guard <= GUARD_RST;
      unlocked            <= 1'b0;
      key_first           <= 1'b0;
      io_wr_q             <= 1'b0;
    end else begin
      base_upper          <= next_base_upper;
      access_ctrl         <= next_access_ctrl;
      o_clock_divider     <= next_divider;
      o_write_erase_guard <= next_guard;
      unlocked            <= next_unlocked;
      key_first           <= next_key_first;
      io_wr_q             <= i_req.io_wr;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Indirect address, erase control and outputs.

  fea_erase_timer #(
    .MASS_CYC (MASS_CYC),
    .PAGE_CYC (PAGE_CYC)
  ) u_timer (
    .i_clk        (i_clk),
    .i_nrst       (i_nrst),
    .i_start_mass (i_mass_erase_start),
    .i_start_page (i_page_erase_start && !i_mass_erase_start),
    .o_busy       (erase_busy),
    .o_done       (erase_done)
  );

  logic [17:0] next_io_addr;
  logic        next_done_flag;
  fea_erase_s  next_erase;
  fea_arr_s    next_arr;
  logic [7:0]  next_rdata;
  logic        start_erase;

  assign start_erase = !erase_busy && (i_mass_erase_start || i_page_erase_start);

  always_comb begin
    next_io_addr = o_io_addr;
    if (finish && acc_io && acc_data) begin
      next_io_addr = o_io_addr + 18'h1;
    end else if (i_addr_load) begin
      next_io_addr = i_addr_value;
    end
    // A completion in the clearing cycle still leaves the flag set.
    next_done_flag = erase_done || (o_erase_done_flag && !i_irq_status_rd);
    next_erase = o_erase;
    if (start_erase) begin
      next_erase.active = 1'b1;
      next_erase.mass   = i_mass_erase_start;
      next_erase.info   = i_aux_area_enable;
      next_erase.page   = o_io_addr[PAGE_LSB +: PAGE_W];
    end else if (erase_done) begin
      next_erase.active = 1'b0;
    end
    next_arr       = o_arr;
    next_arr.rd    = (next_state == FEA_COUNT) && next_acc_data && !next_acc_wr;
    next_arr.wr    = (next_state == FEA_DONE) && acc_data && acc_wr;
    next_arr.info  = next_acc_io && i_aux_area_enable;
    next_arr.addr  = next_acc_addr;
    next_arr.wdata = next_acc_wdata;
    next_rdata = o_rdata;
    if (finish && !acc_wr) begin
      case (acc_reg)
        DATA_OFS: next_rdata = i_arr_rdata;
        BASE_OFS: next_rdata = base_upper;
        CTRL_OFS: next_rdata = access_ctrl;
        DIV_OFS: next_rdata = o_clock_divider;
        GUARD_OFS: next_rdata = o_write_erase_guard;
        default: next_rdata = 8'h00;
      endcase
      if (!acc_io) begin
        next_rdata = i_arr_rdata;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_io_addr         <= '0;
      o_erase_done_flag <= 1'b0;
      o_erase           <= '0;
      o_arr             <= '0;
      o_rdata           <= 8'h00;
      o_ack             <= 1'b0;
      o_wait            <= 1'b0;
      o_ext_cs_inhibit  <= 1'b0;
    end else begin
      o_io_addr         <= next_io_addr;
      o_erase_done_flag <= next_done_flag;
      o_erase           <= next_erase;
      o_arr             <= next_arr;
      o_rdata           <= next_rdata;
      o_ack             <= (next_state == FEA_DONE);
      o_wait            <= (next_state == FEA_HOLD) || (next_state == FEA_COUNT);
      o_ext_cs_inhibit  <= (i_req.mem_rd || i_req.mem_wr) && mem_hit;
    end
  end
endmodule
`default_nettype wire

// *** rtl/fea_erase_timer.sv ***
// Self-timed erase counter for the flash erase and access control block.
// Ignores start pulses that arrive while it is busy; the top does not gate them with busy, and gates the page start only with the mass start.
`timescale 1ns/1ns
`default_nettype none
module fea_erase_timer #(
  parameter int MASS_CYC = fea_pkg::MASS_ERASE_CYC,
  parameter int PAGE_CYC = fea_pkg::PAGE_ERASE_CYC
) (
  input  wire logic i_clk,
  input  wire logic i_nrst,
  input  wire logic i_start_mass,
  input  wire logic i_start_page,
  output logic      o_busy,
  output logic      o_done
);
  import fea_pkg::*;

  logic [ERASE_CNT_W-1:0] cnt;
  logic [ERASE_CNT_W-1:0] next_cnt;
  logic                   next_busy;
  logic                   next_done;

  // The erase runs from its own count, so the CPU is free meanwhile except for flash accesses, which the top holds.
  always_comb begin
    next_cnt  = cnt;
    next_busy = o_busy;
    next_done = 1'b0;
    if (!o_busy && i_start_mass) begin
      next_cnt  = ERASE_CNT_W'(MASS_CYC - 1);
      next_busy = 1'b1;
    end else if (!o_busy && i_start_page) begin
      next_cnt  = ERASE_CNT_W'(PAGE_CYC - 1);
      next_busy = 1'b1;
    end else if (o_busy) begin
      if (cnt == '0) begin
        next_busy = 1'b0;
        next_done = 1'b1;
      end else begin
        next_cnt = cnt - 1'b1;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      cnt    <= '0;
      o_busy <= 1'b0;
      o_done <= 1'b0;
    end else begin
      cnt    <= next_cnt;
      o_busy <= next_busy;
      o_done <= next_done;
    end
  end
endmodule
`default_nettype wire

// *** rtl/fea_pkg.sv ***
// Package for the flash erase and access control block.
// Assumes a 50 MHz system clock and an eight-bit CPU I/O register space.
package fea_pkg;

  localparam logic [7:0] KEY_OFS     = 8'hf5;
  localparam logic [7:0] DATA_OFS    = 8'hf6;
  localparam logic [7:0] BASE_OFS    = 8'hf7;
  localparam logic [7:0] CTRL_OFS    = 8'hf8;
  localparam logic [7:0] DIV_OFS     = 8'hf9;
  localparam logic [7:0] GUARD_OFS   = 8'hfa;

  localparam logic [7:0] KEY_FIRST   = 8'hb6;
  localparam logic [7:0] KEY_SECOND  = 8'h49;

  localparam logic [7:0] BASE_RST    = 8'h00;
  localparam logic [7:0] CTRL_RST    = 8'h88;
  localparam logic [7:0] DIV_RST     = 8'h01;
  localparam logic [7:0] GUARD_RST   = 8'hff;
  localparam logic [7:0] GUARD_ALL   = 8'hff;
  localparam logic [7:0] ERASED_BYTE = 8'hff;

  localparam int CTRL_EN_BIT   = 3;
  localparam int CTRL_WAIT_LSB = 5;
  localparam int CTRL_WAIT_MSB = 7;
  localparam logic [7:0] CTRL_WMASK = 8'he8;
  localparam logic [7:0] BASE_WMASK = 8'hfc;

  localparam int ADDR_W   = 18;
  localparam int PAGE_LSB = 11;
  localparam int PAGE_W   = 7;

  localparam int CLK_HZ        = 50000000;
  localparam int MASS_ERASE_MS = 200;
  localparam int PAGE_ERASE_MS = 10;
  localparam int MASS_ERASE_CYC = (CLK_HZ / 1000) * MASS_ERASE_MS;
  localparam int PAGE_ERASE_CYC = (CLK_HZ / 1000) * PAGE_ERASE_MS;
  localparam int ERASE_CNT_W    = 24;

  typedef enum logic [3:0] {
    FEA_IDLE  = 4'b0001,
    FEA_HOLD  = 4'b0010,
    FEA_COUNT = 4'b0100,
    FEA_DONE  = 4'b1000
  } fea_state_e;

  typedef struct packed {
    logic        io_rd;
    logic        io_wr;
    logic        mem_rd;
    logic        mem_wr;
    logic [7:0]  io_addr;
    logic [23:0] mem_addr;
    logic [7:0]  wdata;
  } fea_cpu_req_s;

  typedef struct packed {
    logic              rd;
    logic              wr;
    logic              info;
    logic [ADDR_W-1:0] addr;
    logic [7:0]        wdata;
  } fea_arr_s;

  typedef struct packed {
    logic              active;
    logic              mass;
    logic              info;
    logic [PAGE_W-1:0] page;
  } fea_erase_s;

endpackage
